// >>> src/xover_pkg.sv
// constants, register layout and state types of the cable crossover control block
// assumes one 100 MHz clock shared with the apb slave
package xover_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DWELL_NS = 20000;
  localparam int DWELL_CYCLES = (DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ATTEMPT_W = 4;
  localparam int TIMER_W = 16;

  // ==========================================================
  // register map
  localparam logic [11:0] CROSSOVER_CONTROL_STATUS_OFF = 12'h000;
  localparam int BIT_PD = 7;
  localparam int BIT_AUTO = 6;
  localparam int BIT_CROSSED = 5;
  localparam int BIT_DONE = 4;
  localparam int SEED_LSB = 0;
  localparam int SEED_W = 4;
  localparam logic RST_PD = 1'b1;
  localparam logic RST_AUTO = 1'b1;
  localparam logic RST_CROSSED = 1'b0;
  localparam logic RST_DONE = 1'b0;
  localparam logic [3:0] RST_SEED = 4'h0;
  localparam logic [3:0] INTERNAL_SEED = 4'h5;
  localparam logic [3:0] SEED_ATTEMPT_3 = 4'h9;
  localparam logic [3:0] SEED_ATTEMPT_2 = 4'h8;
  localparam logic [3:0] SEED_ATTEMPT_1 = 4'h5;
  localparam logic [3:0] SEED_ATTEMPT_0 = 4'h4;
  localparam logic [7:0] LFSR_RST = 8'hA5;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_TRY = 2'b01,
    SEQ_LOCKED = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic parallel_detect_assist_en;
    logic auto_pair_switch_en;
    logic pair_crossed_state;
    logic pair_switch_done;
    logic [3:0] pair_switch_seed;
  } ctrl_t;

  typedef struct packed {
    ctrl_t ctrl;
    seq_state_t seq;
    logic [ATTEMPT_W-1:0] attempt;
    logic [TIMER_W-1:0] timer;
    logic [7:0] lfsr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

endpackage

// >>> src/cable_crossover_control.sv
// apb register bank and pair-selection sequencer for automatic cable crossover
// assumes link_up, local_aneg_en and partner_aneg_seen are synchronous to pclk
//
// Function
// - parallel-detect bit keeps auto-switching alive when local negotiation is off
// - auto-switch enable bit turns on automatic pair selection; resets to one
// - pair-state bit is one for crossed, zero for straight; resets zero
// - pair-state read-only while auto on; writable to force it while off
// - completion bit is one after sequence finishes; zero while running or disabled
// - seed bits 3..0 set the choice on attempts 9, 8, 5 and 4
// - an all-zero seed is replaced by the internal pattern 0101
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module cable_crossover_control
  import xover_pkg::*;
#(
  parameter int DWELL = DWELL_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transceiver side
  input wire logic link_up,
  input wire logic local_aneg_en,
  input wire logic partner_aneg_seen,
  output logic pair_crossed,
  output logic switch_done
);

  // ==========================================================
  // state
  state_t s_q;
  state_t s_d;
  logic allowed;
  logic [3:0] eff_seed;
  logic [ATTEMPT_W-1:0] next_attempt;
  logic [15:0] reg_view;
  logic wr_hit;

  localparam logic [TIMER_W-1:0] DWELL_LAST = TIMER_W'(DWELL - 1);

  function automatic logic pick(input logic [ATTEMPT_W-1:0] n, input logic [3:0] seed,
                                input logic rnd);
    logic r;
    r = rnd;
    if (n == SEED_ATTEMPT_3) begin
      r = seed[3];
    end else if (n == SEED_ATTEMPT_2) begin
      r = seed[2];
    end else if (n == SEED_ATTEMPT_1) begin
      r = seed[1];
    end else if (n == SEED_ATTEMPT_0) begin
      r = seed[0];
    end
    return r;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    // blocked when auto is off, or when we do not negotiate, the partner does, and assist is off
    allowed = s_q.ctrl.auto_pair_switch_en
              & (local_aneg_en | ~partner_aneg_seen
                 | s_q.ctrl.parallel_detect_assist_en);
    eff_seed = (s_q.ctrl.pair_switch_seed == 4'h0) ? INTERNAL_SEED
                                                    : s_q.ctrl.pair_switch_seed;
    next_attempt = s_q.attempt + 1'b1;
    reg_view = {8'h00, s_q.ctrl};
    wr_hit = psel & penable & s_q.pready & pwrite & ~s_q.pslverr;

    // sequencer
    unique case (s_q.seq)
      SEQ_IDLE: begin
        s_d.ctrl.pair_switch_done = 1'b0;
        if (allowed) begin
          s_d.seq = SEQ_TRY;
          s_d.attempt = '0;
          s_d.timer = '0;
          s_d.ctrl.pair_crossed_state = pick('0, eff_seed, s_q.lfsr[0]);
        end
      end
      SEQ_TRY: begin
        if (!allowed) begin
          s_d.seq = SEQ_IDLE;
          s_d.ctrl.pair_switch_done = 1'b0;
        end else if (link_up) begin
          s_d.seq = SEQ_LOCKED;
          s_d.ctrl.pair_switch_done = 1'b1;
        end else if (s_q.timer == DWELL_LAST) begin
          s_d.timer = '0;
          s_d.attempt = next_attempt;
          s_d.lfsr = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};
          s_d.ctrl.pair_crossed_state = pick(next_attempt, eff_seed, s_q.lfsr[7]);
        end else begin
          s_d.timer = s_q.timer + 1'b1;
        end
      end
      SEQ_LOCKED: begin
        if (!allowed) begin
          s_d.seq = SEQ_IDLE;
          s_d.ctrl.pair_switch_done = 1'b0;
        end else if (!link_up) begin
          // link lost: search again from the current choice
          s_d.seq = SEQ_TRY;
          s_d.timer = '0;
          s_d.ctrl.pair_switch_done = 1'b0;
        end
      end
      default: begin
        s_d.seq = SEQ_IDLE;
      end
    endcase

    // apb: zero wait states, answer registered in the setup cycle
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (psel && !penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.pslverr = (paddr != CROSSOVER_CONTROL_STATUS_OFF);
      s_d.prdata = s_d.pslverr ? 32'h0000_0000 : {16'h0000, reg_view};
    end

    // software write, low byte lane only; upper bits are dropped
    if (wr_hit && pstrb[0]) begin
      s_d.ctrl.parallel_detect_assist_en = pwdata[BIT_PD];
      s_d.ctrl.auto_pair_switch_en = pwdata[BIT_AUTO];
      s_d.ctrl.pair_switch_seed = pwdata[SEED_LSB +: SEED_W];
      if (!pwdata[BIT_AUTO]) begin
        s_d.ctrl.pair_crossed_state = pwdata[BIT_CROSSED];
        s_d.ctrl.pair_switch_done = 1'b0;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.ctrl.parallel_detect_assist_en <= RST_PD;
      s_q.ctrl.auto_pair_switch_en <= RST_AUTO;
      s_q.ctrl.pair_crossed_state <= RST_CROSSED;
      s_q.ctrl.pair_switch_done <= RST_DONE;
      s_q.ctrl.pair_switch_seed <= RST_SEED;
      s_q.seq <= SEQ_IDLE;
      s_q.attempt <= '0;
      s_q.timer <= '0;
      s_q.lfsr <= LFSR_RST;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign pair_crossed = s_q.ctrl.pair_crossed_state;
  assign switch_done = s_q.ctrl.pair_switch_done;

endmodule

// >>> verification/xover_props.sv
// checker for the crossover register bank
// sees only the bank's top ports
`timescale 1ns/1ps
module xover_props (
  // all ports watched
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic link_up, local_aneg_en, partner_aneg_seen, pair_crossed, switch_done,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb
);
  // ==========
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_wr; psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[0]; endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_once; pready |=> !pready; endproperty
  property p_upper; pready |-> prdata[31:8] == 24'h000000; endproperty
  property p_err; pready && paddr != 12'h000 |-> pslverr && prdata == 32'h00000000; endproperty
  property p_force; (s_wr ##0 !pwdata[6]) |=> pair_crossed == $past(pwdata[5]); endproperty
  property p_off; (s_wr ##0 !pwdata[6]) |-> ##2 !switch_done; endproperty
  property p_rise; $rose(switch_done) |-> $past(link_up); endproperty
  property p_drop; switch_done && !link_up |=> !switch_done; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_once: assert property (p_once) else $error("ready longer than one cycle");
  a_upper: assert property (p_upper) else $error("upper bits not zero");
  a_err: assert property (p_err) else $error("unmapped access not refused");
  a_force: assert property (p_force) else $error("forced pair not taken");
  a_off: assert property (p_off) else $error("done set with auto off");
  a_rise: assert property (p_rise) else $error("done rose without link");
  a_drop: assert property (p_drop) else $error("done kept after link loss");
endmodule

// >>> verification/link_partner.sv
// link partner model across the cable
// assumes en and want come from the bench
`timescale 1ns/1ps
module link_partner (
  // control and line
  input wire logic pclk,
  input wire logic en,
  input wire logic want,
  input wire logic pair_crossed,
  output logic link_up
);
  // ==========
  // lock-in: two matching cycles, so a passing pair choice never links
  logic [1:0] ok_q = 2'b00;
  always_ff @(posedge pclk) ok_q <= {ok_q[0], en && pair_crossed == want};
  assign link_up = &ok_q;
endmodule

// >>> verification/cable_crossover_control_bench.sv
// self-checking bench for the crossover register bank
// assumes checker and partner model compile first
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module cable_crossover_control_bench;
  // ==========
  // stimulus and model
  localparam int DW = 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic local_aneg_en = 1, partner_aneg_seen = 0, want = 0, en = 0;
  logic link_up, pready, pslverr, pair_crossed, switch_done;
  logic [11:0] paddr = 12'h000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [15:0] rnd = 16'h0010;
  logic [3:0] exp;
  logic [3:0] seeds[$] = '{4'h0, 4'hA};
  int mismatches = 0, tests_run = 0, cyc = 0, k;
  int att[4] = '{4, 5, 8, 9};
  cable_crossover_control #(.DWELL(DW)) DUT (.*);
  link_partner lp (.*);
  initial forever #5 pclk = ~pclk;
  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task tally_and_finish;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    `CHK("pair_in_reset", 1'b0, pair_crossed)
    presetn <= 1;
    apb(0, 12'h000, 0);
    `CHK("reset_value", 32'h000000C0, rd & 32'hFFFFFFDF)
    $display("end reset test");
    rnd = lfsr(rnd);
    seeds.push_back(rnd[3:0]);
    foreach (seeds[i]) begin
      apb(1, 12'h000, 32'h000000A0);
      #1 `CHK("forced_pair", 1'b1, pair_crossed)
      apb(1, 12'h000, {24'h000000, 4'hC, seeds[i]});
      exp = seeds[i] == 4'h0 ? 4'h5 : seeds[i];
      k = 0;
      repeat (2) @(posedge pclk);
      foreach (att[j]) begin
        repeat ((att[j] - k) * DW) @(posedge pclk);
        k = att[j];
        #1 `CHK("seeded_try", exp[j], pair_crossed)
      end
    end
    $display("end seed test");
    local_aneg_en <= 0;
    partner_aneg_seen <= 1;
    want <= rnd[4];
    en <= 1;
    apb(1, 12'h000, 32'h000000C0);
    repeat (200) if (switch_done !== 1'b1) @(posedge pclk);
    #1 `CHK("done_link", 1'b1, switch_done)
    `CHK("pair_link", want, pair_crossed)
    apb(0, 12'h000, 0);
    `CHK("read_state", {want, 1'b1}, rd[5:4])
    apb(1, 12'h000, 32'h00000040);
    repeat (3) @(posedge pclk);
    #1 `CHK("no_assist", 1'b0, switch_done)
    $display("end link test");
    apb(1, 12'h000, 32'hFFFFFF00);
    apb(0, 12'h000, 0);
    `CHK("upper_ignored", 32'h00000000, rd)
    pstrb <= 4'h0;
    apb(1, 12'h000, 32'h000000C0);
    pstrb <= 4'hF;
    apb(0, 12'h000, 0);
    `CHK("strobe_ignored", 32'h00000000, rd)
    apb(0, 12'h004, 0);
    `CHK("unmapped", 1'b1, er)
    $display("end access test");
    tally_and_finish();
  end
endmodule
bind cable_crossover_control xover_props u_props (.*);
